/* hdl/elc_regs.svh */
`ifndef ELC_REGS_SVH
`define ELC_REGS_SVH

// register byte offsets
`define ELC_OFF_CTRL     8'h00
`define ELC_OFF_LINES    8'h04
`define ELC_OFF_DEVTYPE  8'h08
`define ELC_OFF_POLES    8'h0C
`define ELC_OFF_EFF      8'h10
`define ELC_OFF_STATUS   8'h14
`define ELC_OFF_IRQ_STAT 8'h18
`define ELC_OFF_IRQ_MASK 8'h1C

// control fields
`define ELC_CTRL_NEWFW   0
`define ELC_CTRL_LINEAR  1
`define ELC_CTRL_AUTOCFG 2
`define ELC_CTRL_REINIT  3
`define ELC_CTRL_RST     3'h1

// status fields
`define ELC_ST_DONE      0
`define ELC_ST_ENABLED   1
`define ELC_ST_COMM      2

// interrupt fields
`define ELC_IRQ_DONE     0
`define ELC_IRQ_START    1
`define ELC_IRQ_REFUSE   2
`define ELC_IRQ_W        3

// reset values and last device type
`define ELC_LINES_RST    16'h0400
`define ELC_POLES_RST    16'h0606
`define ELC_DEV_LAST     4'h9

// line count limits
`define ELC_LINES_MAX    16'hC350
`define ELC_OLD_INC_MAX  16'h4000
`define ELC_SINCOS_CAP   16'h8000
`define ELC_MIN_TWO      16'h0002
`define ELC_MIN_ONE      16'h0001
`define ELC_MUL4_MASK    16'hFFFC

// timing
`define ELC_COMM_DEG     7'h78
`define ELC_SETTLE       3'h4

`endif

/* hdl/elc_pkg.sv */
package elc_pkg;

    typedef enum logic [3:0] {
        quadrature_incremental,
        pulse_direction_incremental,
        up_down_count_incremental,
        quadrature_with_commutation,
        pulse_direction_with_commutation,
        up_down_with_commutation,
        sine_cosine_incremental,
        sincos_serial_variant_one,
        sincos_serial_variant_two,
        sincos_with_ssi
    } elc_dev_t;

    typedef enum logic [2:0] {
        st_calc,
        st_reinit,
        st_settle,
        st_wait,
        st_done
    } elc_state_t;

endpackage

/* hdl/elc_lines_calc.sv */
`timescale 1ns/1ps
`include "elc_regs.svh"

module elc_lines_calc (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [15:0]      setting,
    input  elc_pkg::elc_dev_t     dev,
    input  wire logic             new_fw,
    input  wire logic             linear,
    output logic      [15:0]      eff_q
);
    import elc_pkg::*;

    logic [15:0] pow2;
    logic [15:0] eff_d;
    logic        plain;
    logic        servo;
    logic        serial;

    ////////////////////////////////////////////////////////////////////////
    // highest set bit of the setting
    always_comb begin
        pow2 = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (setting[i]) begin
                pow2 = 16'(`ELC_MIN_ONE << i);
            end
        end
    end

    assign plain  = dev inside {quadrature_incremental, pulse_direction_incremental,
                                up_down_count_incremental};
    assign servo  = dev inside {quadrature_with_commutation, pulse_direction_with_commutation,
                                up_down_with_commutation};
    assign serial = dev inside {sincos_serial_variant_one, sincos_serial_variant_two,
                                sincos_with_ssi};

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        eff_d = setting;
        if (new_fw) begin
            if (serial && !linear) begin
                if (setting <= `ELC_MIN_ONE) begin
                    eff_d = `ELC_MIN_ONE;
                end else if (setting >= `ELC_SINCOS_CAP) begin
                    eff_d = `ELC_SINCOS_CAP;
                end else begin
                    eff_d = pow2;
                end
            end else begin
                eff_d = setting;
            end
        end else if (plain) begin
            if (setting < `ELC_MIN_TWO) begin
                eff_d = `ELC_MIN_TWO;
            end else if (setting <= `ELC_OLD_INC_MAX) begin
                eff_d = setting;
            end else begin
                eff_d = setting & `ELC_MUL4_MASK;
            end
        end else if (servo) begin
            if (setting <= `ELC_MIN_TWO) begin
                eff_d = `ELC_MIN_TWO;
            end else if (setting >= `ELC_OLD_INC_MAX) begin
                eff_d = `ELC_OLD_INC_MAX;
            end else begin
                eff_d = pow2;
            end
        end else begin
            if (setting <= `ELC_MIN_TWO) begin
                eff_d = `ELC_MIN_TWO;
            end else if (setting >= `ELC_SINCOS_CAP) begin
                eff_d = `ELC_SINCOS_CAP;
            end else begin
                eff_d = pow2;
            end
        end
    end

    // one cycle of latency, recomputed every edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_q <= `ELC_MIN_TWO;
        end else begin
            eff_q <= eff_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_new_unchanged: assert property (@(posedge pclk) disable iff (!presetn)
        new_fw && (!serial || linear) |=> eff_q == $past(setting))
        else $error("new generation value not passed through");

    a_new_rotary: assert property (@(posedge pclk) disable iff (!presetn)
        new_fw && serial && !linear |=> (eff_q & (eff_q - 16'h0001)) == 16'h0000
            && eff_q <= `ELC_SINCOS_CAP && (eff_q <= $past(setting) || eff_q == 16'h0001))
        else $error("rotary absolute value not a clamped power of two");

    a_old_plain: assert property (@(posedge pclk) disable iff (!presetn)
        !new_fw && plain && setting > `ELC_OLD_INC_MAX
            |=> eff_q == ($past(setting) & `ELC_MUL4_MASK))
        else $error("old plain value not rounded to multiple of four");

    a_old_servo: assert property (@(posedge pclk) disable iff (!presetn)
        !new_fw && servo |=> (eff_q & (eff_q - 16'h0001)) == 16'h0000
            && eff_q >= `ELC_MIN_TWO && eff_q <= `ELC_OLD_INC_MAX)
        else $error("old commutation value out of range");

    a_old_sincos: assert property (@(posedge pclk) disable iff (!presetn)
        !new_fw && !plain && !servo |=> (eff_q & (eff_q - 16'h0001)) == 16'h0000
            && eff_q >= `ELC_MIN_TWO && eff_q <= `ELC_SINCOS_CAP)
        else $error("old sine cosine value out of range");

endmodule // elc_lines_calc

/* hdl/elc_core.sv */
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "elc_regs.svh"


module elc_core (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             enc_init_done_in,
    input  wire logic [2:0]       opt_present_in,
    input  wire logic [2:0]       opt_init_done_in,
    input  wire logic             enc_has_comms,
    input  wire logic             aux_supply_fault_reset,
    input  wire logic             encoder_fault_range_a_reset,
    input  wire logic             encoder_fault_range_b_reset,
    input  wire logic             drive_enable_req,
    input  wire logic             motor_restart,
    input  wire logic             elec_deg_step,
    output logic                  enc_reinit,
    output logic                  enc_autocfg,
    output logic                  init_done_flag,
    output logic                  drive_enabled,
    output logic                  commutation_active,
    output logic      [15:0]      eff_lines,
    output logic                  irq
);
    import elc_pkg::*;

    logic [2:0]         ctrl_q;
    logic [15:0]        line_count_setting_q;
    elc_dev_t           dev_q;
    logic [7:0]         pole_count_map_one_q;
    logic [7:0]         pole_count_map_two_q;
    logic [`ELC_IRQ_W-1:0] irq_stat_q;
    logic [`ELC_IRQ_W-1:0] irq_mask_q;
    logic [`ELC_IRQ_W-1:0] irq_set;
    elc_state_t         state_q;
    logic [2:0]         settle_q;
    logic [6:0]         comm_deg_q;
    logic [6:0]         sync1_q;
    logic [6:0]         sync2_q;
    logic               all_done;
    logic               servo_dev;
    logic               acc;
    logic               wr_fire;
    logic               rd_fire;
    logic               hit;
    logic [31:0]        rd_mux;
    logic               setting_ok;
    logic               lines_chg;
    logic               dev_chg;
    logic               poles_chg;
    logic               reinit_wr;
    logic               init_start;

    ////////////////////////////////////////////////////////////////////////
    // encoder and option module readiness arrives from other logic; synchronise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else begin
            sync1_q <= {opt_present_in, opt_init_done_in, enc_init_done_in};
            sync2_q <= sync1_q;
        end
    end

    // absent option slots count as finished
    assign all_done = sync2_q[0] && ((sync2_q[3:1] | ~sync2_q[6:4]) == 3'h7);

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, pready comes from a flop
    assign acc     = psel && penable;
    assign wr_fire = acc && pready && pwrite;
    assign rd_fire = acc && pready && !pwrite;

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == `ELC_OFF_CTRL) begin
            rd_mux = {29'h0000_0000, ctrl_q};
        end else if (paddr == `ELC_OFF_LINES) begin
            rd_mux = {16'h0000, line_count_setting_q};
        end else if (paddr == `ELC_OFF_DEVTYPE) begin
            rd_mux = {28'h000_0000, dev_q};
        end else if (paddr == `ELC_OFF_POLES) begin
            rd_mux = {16'h0000, pole_count_map_two_q, pole_count_map_one_q};
        end else if (paddr == `ELC_OFF_EFF) begin
            rd_mux = {16'h0000, eff_lines};
        end else if (paddr == `ELC_OFF_STATUS) begin
            rd_mux = {29'h0000_0000, commutation_active, drive_enabled, init_done_flag};
        end else if (paddr == `ELC_OFF_IRQ_STAT) begin
            rd_mux = {29'h0000_0000, irq_stat_q};
        end else if (paddr == `ELC_OFF_IRQ_MASK) begin
            rd_mux = {29'h0000_0000, irq_mask_q};
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !hit;
            prdata  <= (acc && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; out of range line settings are dropped
    assign setting_ok = pwdata[31:16] == 16'h0000 && pwdata[15:0] <= `ELC_LINES_MAX;
    assign lines_chg  = wr_fire && paddr == `ELC_OFF_LINES && setting_ok
                        && pwdata[15:0] != line_count_setting_q;
    assign dev_chg    = wr_fire && paddr == `ELC_OFF_DEVTYPE && pwdata[3:0] <= `ELC_DEV_LAST
                        && pwdata[3:0] != dev_q;
    assign poles_chg  = wr_fire && paddr == `ELC_OFF_POLES
                        && pwdata[15:0] != {pole_count_map_two_q, pole_count_map_one_q};
    assign reinit_wr  = wr_fire && paddr == `ELC_OFF_CTRL && pwdata[`ELC_CTRL_REINIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q               <= `ELC_CTRL_RST;
            line_count_setting_q <= `ELC_LINES_RST;
            dev_q                <= quadrature_incremental;
            pole_count_map_one_q <= 8'(`ELC_POLES_RST);
            pole_count_map_two_q <= 8'(`ELC_POLES_RST >> 8);
            irq_mask_q           <= 3'h0;
        end else begin
            if (wr_fire && paddr == `ELC_OFF_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (lines_chg) begin
                line_count_setting_q <= pwdata[15:0];
            end
            if (dev_chg) begin
                dev_q <= elc_dev_t'(pwdata[3:0]);
            end
            if (poles_chg) begin
                pole_count_map_one_q <= pwdata[7:0];
                pole_count_map_two_q <= pwdata[15:8];
            end
            if (wr_fire && paddr == `ELC_OFF_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    elc_lines_calc u_calc (
        .pclk    (pclk),
        .presetn (presetn),
        .setting (line_count_setting_q),
        .dev     (dev_q),
        .new_fw  (ctrl_q[`ELC_CTRL_NEWFW]),
        .linear  (ctrl_q[`ELC_CTRL_LINEAR]),
        .eff_q   (eff_lines)
    );

    ////////////////////////////////////////////////////////////////////////
    // initialisation sequencing; power-up enters through st_calc
    assign init_start = reinit_wr || aux_supply_fault_reset || encoder_fault_range_a_reset
                        || encoder_fault_range_b_reset || lines_chg || poles_chg
                        || dev_chg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= st_calc;
            settle_q <= 3'h0;
        end else if (init_start) begin
            state_q  <= st_calc;
            settle_q <= 3'h0;
        end else begin
            case (state_q)
                st_calc: begin
                    state_q <= st_reinit;
                end
                st_reinit: begin
                    state_q <= st_settle;
                end
                st_settle: begin
                    // lets stale done levels drop before they are trusted
                    settle_q <= settle_q + 3'h1;
                    if (settle_q == `ELC_SETTLE) begin
                        state_q <= st_wait;
                    end
                end
                st_wait: begin
                    if (all_done) begin
                        state_q <= st_done;
                    end
                end
                default: begin
                    state_q <= st_done;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done_flag <= 1'b0;
        end else if (init_start) begin
            init_done_flag <= 1'b0;
        end else if (state_q == st_wait && all_done) begin
            init_done_flag <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_reinit  <= 1'b0;
            enc_autocfg <= 1'b0;
        end else begin
            enc_reinit  <= state_q == st_reinit && !init_start && enc_has_comms;
            enc_autocfg <= state_q == st_reinit && !init_start && enc_has_comms
                           && ctrl_q[`ELC_CTRL_AUTOCFG];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_enabled <= 1'b0;
        end else begin
            drive_enabled <= drive_enable_req && init_done_flag && !init_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // commutation-signal position for the first electrical degrees after restart
    assign servo_dev = dev_q inside {quadrature_with_commutation,
                                     pulse_direction_with_commutation,
                                     up_down_with_commutation};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            commutation_active <= 1'b0;
            comm_deg_q         <= 7'h00;
        end else if (init_start) begin
            commutation_active <= 1'b0;
            comm_deg_q         <= 7'h00;
        end else if (motor_restart && init_done_flag && servo_dev) begin
            commutation_active <= 1'b1;
            comm_deg_q         <= 7'h00;
        end else if (commutation_active && elec_deg_step) begin
            if (comm_deg_q == 7'(`ELC_COMM_DEG - 7'h01)) begin
                commutation_active <= 1'b0;
            end
            comm_deg_q <= comm_deg_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, cleared by reading it; a new event beats the clear
    assign irq_set[`ELC_IRQ_DONE]   = state_q == st_wait && all_done && !init_start;
    assign irq_set[`ELC_IRQ_START]  = init_start;
    assign irq_set[`ELC_IRQ_REFUSE] = drive_enable_req && !init_done_flag;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
            irq        <= 1'b0;
        end else begin
            if (rd_fire && paddr == `ELC_OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~prdata[2:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_setting_range: assert property (@(posedge pclk) disable iff (!presetn)
        line_count_setting_q <= `ELC_LINES_MAX)
        else $error("line setting above limit");

    a_done_needs_all: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(init_done_flag) |-> $past(all_done) && $past(state_q) == st_wait)
        else $error("done flag set before all encoders ready");

    a_enable_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !init_done_flag |=> !drive_enabled)
        else $error("drive enabled without init done");

    a_trigger_clears: assert property (@(posedge pclk) disable iff (!presetn)
        init_start |=> !init_done_flag && state_q == st_calc ##1 state_q == st_reinit
            || $past(init_start))
        else $error("init trigger did not restart sequence");

    a_reinit_comms: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_reinit && !init_start && enc_has_comms
            |=> enc_reinit && enc_autocfg == $past(ctrl_q[`ELC_CTRL_AUTOCFG]) ##1 !enc_reinit)
        else $error("communicating encoder not re-initialised");

    a_comm_window: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(commutation_active) && !$past(init_start)
            |-> $past(comm_deg_q) == 7'(`ELC_COMM_DEG - 7'h01))
        else $error("commutation window length wrong");

    a_eff_before_done: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(init_done_flag) |-> $stable(eff_lines) && $past(eff_lines, 2) == eff_lines)
        else $error("effective count still moving at done");

endmodule // elc_core

/* test/elc_enc_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module elc_enc_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       enc_reinit,
    input  wire logic [3:0] delay,
    output logic            done
);
    logic [3:0] cnt_q;
    // busy while own setup runs; delay picks a prompt or a slow encoder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'hF;
            done  <= 1'b0;
        end else if (enc_reinit) begin
            cnt_q <= delay;
            done  <= 1'b0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            done <= 1'b1;
        end
    end
endmodule // elc_enc_model

/* test/testbench.sv */
`timescale 1ns/1ps
`include "elc_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////////////
module testbench;
    import elc_pkg::*;
    typedef struct {logic [3:0] ctrl; logic [3:0] dev; logic [15:0] set; logic [15:0] eff;} elc_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, enc_done;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, req = 0, comms = 1;
    logic [2:0] opt_done = 0;
    // pulse lines: [2:0] trip resets, [3] motor restart, [4] degree step
    logic [4:0] pv = 0;
    logic enc_reinit, enc_autocfg, init_done_flag, drive_enabled, comm, irq;
    logic [15:0] eff_lines;
    int fails = 0, cmp_count = 0, ac_seen = 0, ri_seen = 0, ri0 = 0;
    elc_row_t rows[16] = '{
        '{1, 0, 50000, 50000}, '{1, 7, 1, 1}, '{1, 8, 40000, 32768},
        '{1, 9, 5000, 4096}, '{1, 6, 12345, 12345}, '{3, 8, 40000, 40000},
        '{0, 0, 1, 2}, '{0, 1, 16384, 16384}, '{0, 2, 16387, 16384},
        '{0, 3, 3000, 2048}, '{0, 4, 20000, 16384}, '{0, 5, 2, 2},
        '{0, 6, 40000, 32768}, '{0, 7, 3, 2}, '{1, 9, 32767, 16384},
        '{0, 4, 16383, 8192}};
    initial forever #25 pclk = ~pclk;
    elc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_init_done_in(enc_done),
        .opt_present_in(3'h1), .opt_init_done_in(opt_done), .enc_has_comms(comms),
        .aux_supply_fault_reset(pv[0]), .encoder_fault_range_a_reset(pv[1]),
        .encoder_fault_range_b_reset(pv[2]), .drive_enable_req(req),
        .motor_restart(pv[3]), .elec_deg_step(pv[4]), .enc_reinit(enc_reinit),
        .enc_autocfg(enc_autocfg), .init_done_flag(init_done_flag),
        .drive_enabled(drive_enabled), .commutation_active(comm),
        .eff_lines(eff_lines), .irq(irq));
    elc_enc_model enc (.pclk(pclk), .presetn(presetn), .enc_reinit(enc_reinit),
        .delay(4'h9), .done(enc_done));
    always @(posedge pclk) if (enc_reinit && enc_autocfg) ac_seen++;
    always @(posedge pclk) if (enc_reinit) ri_seen++;
    task finish_test();
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // request held until pready sampled high; read data taken at that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        if (n == 20) begin fails++; finish_test(); end
    endtask
    task wait_done();
        int n;
        // one edge first so a trigger taken at this edge has cleared the flag
        @(posedge pclk);
        for (n = 0; n < 200 && init_done_flag !== 1'b1; n++) @(posedge pclk);
        if (n == 200) begin fails++; finish_test(); end
    endtask
    task pulse(input int k);
        @(posedge pclk); pv[k] <= 1; @(posedge pclk); pv[k] <= 0;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1; req <= 1;
        repeat (40) @(posedge pclk);
        `CHK(init_done_flag, 1'b0)
        `CHK(drive_enabled, 1'b0)
        opt_done <= 3'h1;
        wait_done();
        repeat (2) @(posedge pclk);
        `CHK(drive_enabled, 1'b1)
        foreach (rows[i]) begin
            apb(1, `ELC_OFF_CTRL, rows[i].ctrl);
            apb(1, `ELC_OFF_DEVTYPE, rows[i].dev);
            apb(1, `ELC_OFF_LINES, rows[i].set);
            wait_done();
            apb(0, `ELC_OFF_EFF, 0);
            `CHK(rd[15:0], rows[i].eff)
            `CHK(eff_lines, rows[i].eff)
        end
        apb(1, `ELC_OFF_LINES, 32'd50001);
        apb(0, `ELC_OFF_LINES, 0);
        `CHK(rd[15:0], 16'd16383)
        req <= 0;
        apb(1, `ELC_OFF_IRQ_MASK, 7);
        for (int t = 0; t < 4; t++) begin
            apb(0, `ELC_OFF_IRQ_STAT, 0);
            if (t < 3) pulse(t);
            else apb(1, `ELC_OFF_POLES, 16'h0707);
            repeat (3) @(posedge pclk);
            `CHK(init_done_flag, 1'b0)
            `CHK(irq, 1'b1)
            wait_done();
        end
        apb(1, `ELC_OFF_CTRL, 32'hD);
        wait_done();
        `CHK(ac_seen != 0, 1'b1)
        comms <= 0;
        ri0 = ri_seen;
        apb(1, `ELC_OFF_CTRL, 32'h9);
        wait_done();
        `CHK(ri_seen, ri0)
        comms <= 1;
        apb(0, `ELC_OFF_IRQ_STAT, 0);
        apb(0, `ELC_OFF_IRQ_STAT, 0);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(0, 8'h20, 0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1, `ELC_OFF_DEVTYPE, 3);
        wait_done();
        pulse(3);
        repeat (2) @(posedge pclk);
        `CHK(comm, 1'b1)
        repeat (119) pulse(4);
        `CHK(comm, 1'b1)
        pulse(4);
        repeat (2) @(posedge pclk);
        `CHK(comm, 1'b0)
        // reset in mid-run: flag drops at once, power-up init runs again
        presetn <= 0;
        @(posedge pclk);
        `CHK(init_done_flag, 1'b0)
        `CHK(eff_lines, 16'h0002)
        presetn <= 1;
        wait_done();
        `CHK(eff_lines, 16'h0400)
        finish_test();
    end
endmodule // testbench
